/* File: rtl/pasp_port.sv */
// port a registers, pin drivers and peripheral pin steering
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.
`default_nettype none
module pasp_port #(
   parameter bit SMALL_PKG = 1'b1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // classic wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // port a pins
   input wire logic [5:0] pa_in_i,
   output logic [5:0] pa_out_o,
   output logic [5:0] pa_oe_o,
   // port b/c pins that steering touches (raw inputs)
   input wire logic [6:1] pc_in_i,
   input wire logic pb4_in_i,
   // peripheral side
   input wire pasp_pkg::pasp_periph_t periph_i,
   output pasp_pkg::pasp_pin_in_t periph_o,
   output pasp_pkg::pasp_pinc_t pinc_o
);
   import pasp_pkg::*;

   logic [5:0] pa_s1_q, pa_s2_q;
   logic [6:1] pc_s1_q, pc_s2_q;
   logic pb_s1_q, pb_s2_q;
   logic [5:0] lat_q, dir_q, ansel_q;
   logic [7:0] steer_q;
   logic [5:0] levels;
   logic [7:0] steer_mask;
   logic [31:0] rdata_d;
   logic wr, rd_hit;
   logic [5:0] pa_ovr, pa_ovr_val;

   // two-stage synchronisers; first stage read only by second
   always_ff @(posedge clk_i) begin
      pa_s1_q <= pa_in_i;
      pa_s2_q <= pa_s1_q;
      pc_s1_q <= pc_in_i;
      pc_s2_q <= pc_s1_q;
      pb_s1_q <= pb4_in_i;
      pb_s2_q <= pb_s1_q;
   end

   // analog pins read zero, bit3 has no analog select
   assign levels = pa_s2_q & ~ansel_q;

   assign steer_mask = SMALL_PKG ? PASP_STEER_MASK_14 : PASP_STEER_MASK_20;
   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

   // ack one cycle after strobe, drops the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
      end else begin
         ack_o <= cyc_i && stb_i && !ack_o;
      end
   end

   // output latch: level and latch writes share it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         lat_q <= PASP_LATCH_RST;
      end else if (wr && (adr_i[4:2] == PASP_OFS_LEVELS ||
                          adr_i[4:2] == PASP_OFS_LATCH)) begin
         // written bits 5:0 replace the latch, bit3 held zero, the modify step is software's
         lat_q <= dat_i[5:0] & PASP_IMPL_MASK;
      end
   end

   // direction: bit3 pinned to input
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dir_q <= PASP_DIR_RST;
      end else if (wr && adr_i[4:2] == PASP_OFS_DIR) begin
         dir_q <= dat_i[5:0] | PASP_BIT3;
      end
   end

   // analog select resets to analog on every pin but bit3
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ansel_q <= PASP_ANSEL_RST;
      end else if (wr && adr_i[4:2] == PASP_OFS_ANSEL) begin
         ansel_q <= dat_i[5:0] & PASP_IMPL_MASK;
      end
   end

   // steering register, unimplemented bits held at zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         steer_q <= PASP_STEER_RST;
      end else if (wr && adr_i[4:2] == PASP_OFS_STEER) begin
         steer_q <= dat_i[7:0] & steer_mask;
      end
   end

   // read mux registered; unmapped reads zero
   always_comb begin
      rdata_d = 32'h0;
      case (adr_i[4:2])
         PASP_OFS_LEVELS: rdata_d[5:0] = levels;
         PASP_OFS_LATCH: rdata_d[5:0] = lat_q;
         PASP_OFS_DIR: rdata_d[5:0] = dir_q;
         PASP_OFS_ANSEL: rdata_d[5:0] = ansel_q;
         PASP_OFS_STEER: rdata_d[7:0] = steer_q;
         default: rdata_d = 32'h0;
      endcase
   end
   assign rd_hit = cyc_i && stb_i && !we_i && !ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0;
      end else if (rd_hit) begin
         dat_o <= rdata_d;
      end
   end

   // port a overrides from sdo on a4 when steered there
   always_comb begin
      pa_ovr = 6'h00;
      pa_ovr_val = 6'h00;
      if (steer_q[PASP_SB_SDO] && periph_i.sdo_oe) begin
         pa_ovr[4] = 1'b1;
         pa_ovr_val[4] = periph_i.sdo;
      end
   end

   // drivers: direction gates, analog select ignored, peripheral wins
   always_comb begin
      pa_out_o = (lat_q & ~pa_ovr) | (pa_ovr_val & pa_ovr);
      pa_oe_o = (~dir_q | pa_ovr) & PASP_IMPL_MASK;
   end

   // steered peripheral inputs
   always_comb begin
      periph_o.rx = steer_q[PASP_SB_RX] ? levels[4] : pc_s2_q[5];
      periph_o.ss_n = steer_q[PASP_SB_SS] ?
                      (SMALL_PKG ? pc_s2_q[3] : pc_s2_q[6]) :
                      pa_s2_q[3];
      periph_o.sdi = steer_q[PASP_SB_SDI] ? pa_s2_q[3] :
                     (SMALL_PKG ? pc_s2_q[1] : pb_s2_q);
   end

   // port c output overrides; unselected pins left alone
   always_comb begin
      pinc_o = '0;
      if (!steer_q[PASP_SB_SDO] && periph_i.sdo_oe) begin
         pinc_o.c_ovr[2] = 1'b1;
         pinc_o.c_out[2] = periph_i.sdo;
         pinc_o.c_oe[2] = 1'b1;
      end
      if (periph_i.tx_oe) begin
         if (steer_q[PASP_SB_TX]) begin
            pinc_o.c_ovr[3] = 1'b1;
            pinc_o.c_out[3] = periph_i.tx;
            pinc_o.c_oe[3] = 1'b1;
         end else begin
            pinc_o.c_ovr[4] = 1'b1;
            pinc_o.c_out[4] = periph_i.tx;
            pinc_o.c_oe[4] = 1'b1;
         end
      end
      if (periph_i.guard_en) begin
         pinc_o.c_ovr[3:2] = 2'h3;
         pinc_o.c_oe[3:2] = 2'h3;
         pinc_o.c_out[2] = steer_q[PASP_SB_GB] ?
                           periph_i.g2b : periph_i.g1b;
         pinc_o.c_out[3] = steer_q[PASP_SB_GB] ?
                           periph_i.g1b : periph_i.g2b;
         pinc_o.c_ovr[5:4] = 2'h3;
         pinc_o.c_oe[5:4] = 2'h3;
         pinc_o.c_out[4] = steer_q[PASP_SB_GA] ?
                           periph_i.g2a : periph_i.g1a;
         pinc_o.c_out[5] = steer_q[PASP_SB_GA] ?
                           periph_i.g1a : periph_i.g2a;
      end
   end

   // checks
   property p_dir3;
      @(posedge clk_i) disable iff (rst_i) dir_q[3];
   endproperty
   a_dir3: assert property (p_dir3) else $error("dir bit3 not one");

   property p_ansel_rst;
      @(posedge clk_i) $fell(rst_i) |-> ansel_q == PASP_ANSEL_RST;
   endproperty
   a_ansel_rst: assert property (p_ansel_rst)
      else $error("analog reset wrong");

   property p_latch_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr && adr_i[4:2] == PASP_OFS_LEVELS |=>
      lat_q == ($past(dat_i[5:0]) & PASP_IMPL_MASK);
   endproperty
   a_latch_wr: assert property (p_latch_wr)
      else $error("level write missed latch");

   property p_oe;
      @(posedge clk_i) disable iff (rst_i)
      pa_ovr == 6'h00 |-> pa_oe_o == (~dir_q & PASP_IMPL_MASK);
   endproperty
   a_oe: assert property (p_oe) else $error("oe mismatch");

   property p_analog_out;
      @(posedge clk_i) disable iff (rst_i)
      pa_ovr == 6'h00 |-> pa_out_o == lat_q;
   endproperty
   a_analog_out: assert property (p_analog_out)
      else $error("output not from latch");

   sequence s_rd_level;
      rd_hit && adr_i[4:2] == PASP_OFS_LEVELS;
   endsequence
   property p_rd_level;
      @(posedge clk_i) disable iff (rst_i)
      s_rd_level |=> ack_o && (dat_o[5:0] & $past(ansel_q)) == 6'h00;
   endproperty
   a_rd_level: assert property (p_rd_level)
      else $error("analog pin read nonzero");

   property p_steer3;
      @(posedge clk_i) disable iff (rst_i) steer_q[3] == 1'b0;
   endproperty
   a_steer3: assert property (p_steer3) else $error("steer bit3 set");

   property p_ack;
      @(posedge clk_i) disable iff (rst_i)
      cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing");

   property p_guard;
      @(posedge clk_i) disable iff (rst_i)
      periph_i.guard_en && !steer_q[PASP_SB_GA] |->
      pinc_o.c_out[4] == periph_i.g1a;
   endproperty
   a_guard: assert property (p_guard) else $error("guard a route");

   // register writes land at the edge that takes the strobe
   property p_latch_alias;
      @(posedge clk_i) disable iff (rst_i)
      wr && adr_i[4:2] == PASP_OFS_LATCH |=>
      lat_q == ($past(dat_i[5:0]) & PASP_IMPL_MASK);
   endproperty
   a_latch_alias: assert property (p_latch_alias)
      else $error("latch write missed");

   property p_dir_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr && adr_i[4:2] == PASP_OFS_DIR |=>
      dir_q == ($past(dat_i[5:0]) | PASP_BIT3);
   endproperty
   a_dir_wr: assert property (p_dir_wr)
      else $error("direction write wrong");

   property p_ansel_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr && adr_i[4:2] == PASP_OFS_ANSEL |=>
      ansel_q == ($past(dat_i[5:0]) & PASP_IMPL_MASK);
   endproperty
   a_ansel_wr: assert property (p_ansel_wr)
      else $error("analog select write wrong");

   // steering keeps only the bits this variant has
   property p_steer_wr;
      @(posedge clk_i) disable iff (rst_i)
      wr && adr_i[4:2] == PASP_OFS_STEER |=>
      steer_q == ($past(dat_i[7:0]) & steer_mask);
   endproperty
   a_steer_wr: assert property (p_steer_wr)
      else $error("steering write wrong");

   // a write without the low byte enable must leave every register alone
   sequence s_wr_no_lane;
      cyc_i && stb_i && we_i && !ack_o && !sel_i[0];
   endsequence
   property p_sel_gate;
      @(posedge clk_i) disable iff (rst_i)
      s_wr_no_lane |=> $stable(lat_q) && $stable(dir_q) &&
      $stable(ansel_q) && $stable(steer_q);
   endproperty
   a_sel_gate: assert property (p_sel_gate)
      else $error("masked write changed a register");

   // only steering fills bits 7:6, nothing fills the upper bytes
   property p_rd_upper;
      @(posedge clk_i) disable iff (rst_i)
      rd_hit && adr_i[4:2] != PASP_OFS_STEER |=> dat_o[31:6] == 26'h0;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("unimplemented bits read nonzero");

   // a read answers one edge after it is taken, from the latch itself
   sequence s_rd_latch;
      rd_hit && adr_i[4:2] == PASP_OFS_LATCH;
   endsequence
   property p_rd_latch;
      @(posedge clk_i) disable iff (rst_i)
      s_rd_latch |=> ack_o && dat_o[5:0] == $past(lat_q);
   endproperty
   a_rd_latch: assert property (p_rd_latch)
      else $error("latch read wrong");

   property p_rd_dir;
      @(posedge clk_i) disable iff (rst_i)
      rd_hit && adr_i[4:2] == PASP_OFS_DIR |=> dat_o[3];
   endproperty
   a_rd_dir: assert property (p_rd_dir)
      else $error("direction bit3 read zero");

   // the input-only pin is never driven, whatever the overrides do
   property p_oe_bit3;
      @(posedge clk_i) disable iff (rst_i) !pa_oe_o[3];
   endproperty
   a_oe_bit3: assert property (p_oe_bit3)
      else $error("input-only pin driven");

   // serial out steered to a4 takes the pin from the latch
   property p_a4_sdo;
      @(posedge clk_i) disable iff (rst_i)
      steer_q[PASP_SB_SDO] && periph_i.sdo_oe |->
      pa_oe_o[4] && pa_out_o[4] == periph_i.sdo;
   endproperty
   a_a4_sdo: assert property (p_a4_sdo)
      else $error("serial out not on a4");

   property p_c2_free;
      @(posedge clk_i) disable iff (rst_i)
      steer_q[PASP_SB_SDO] && !periph_i.guard_en |-> !pinc_o.c_ovr[2];
   endproperty
   a_c2_free: assert property (p_c2_free)
      else $error("unselected pin overridden");

   property p_tx_route;
      @(posedge clk_i) disable iff (rst_i)
      periph_i.tx_oe && !periph_i.guard_en |->
      pinc_o.c_ovr[3] == steer_q[PASP_SB_TX] &&
      pinc_o.c_ovr[4] == !steer_q[PASP_SB_TX];
   endproperty
   a_tx_route: assert property (p_tx_route)
      else $error("transmit on wrong pin");

   property p_guard_b;
      @(posedge clk_i) disable iff (rst_i)
      periph_i.guard_en && steer_q[PASP_SB_GB] |->
      pinc_o.c_out[2] == periph_i.g2b && pinc_o.c_out[3] == periph_i.g1b;
   endproperty
   a_guard_b: assert property (p_guard_b)
      else $error("guard b route");

   // inputs follow the steering bit, taken from synchronised pins only
   property p_rx_route;
      @(posedge clk_i) disable iff (rst_i)
      periph_o.rx == (steer_q[PASP_SB_RX] ? levels[4] : pc_s2_q[5]);
   endproperty
   a_rx_route: assert property (p_rx_route)
      else $error("receive on wrong pin");

   // a pin level reaches the read path two edges after it is sampled
   property p_sync;
      @(posedge clk_i) disable iff (rst_i)
      pa_s2_q == $past(pa_in_i, 2);
   endproperty
   a_sync: assert property (p_sync)
      else $error("pin synchroniser depth wrong");

   // latch, direction, steering and ack are back at their reset values after any reset
   property p_rst_vals;
      @(posedge clk_i) $fell(rst_i) |->
      lat_q == PASP_LATCH_RST && dir_q == PASP_DIR_RST &&
      steer_q == PASP_STEER_RST && !ack_o;
   endproperty
   a_rst_vals: assert property (p_rst_vals)
      else $error("register reset value wrong");
endmodule
`default_nettype wire

/* File: common/pasp_pkg.sv */
// package for the port a and pin steering block: offsets, layouts, resets
// What this block does
// - latch write equals pin-level register write
// - latch reads latch, level reads pins
// - writes replace the latch; read-modify-write is left to software
// - five bidirectional pins plus input-only bit three; direction/latch/analog on the five
// - direction one disables driver, zero drives latch
// - bit three input only, direction reads one
// - analog select disables input, reads zero
// - analog pins read zero in level register
// - analog select never affects digital output
// - direction still controls drivers on analog pins
// - analog select bits reset to analog
// - enabled peripheral takes pin, level stays readable
// - steering never changes direction, routes overrides
// - bit seven: receive on c5 or a4
// - bit six: serial out on c2 or a4
// - bit five: slave select on a3 or c3/c6
// - bit four: serial in on c1/b4 or a3
// - bit two: transmit on c4 or c3
// - bit one: swap guard b drives c2/c3
// - bit zero: swap guard a drives c4/c5
// - bits 7,6,2 only small variant; bit3 zero
// - unimplemented bits read zero, direction bit3 one
`default_nettype none
package pasp_pkg;
   localparam int unsigned PASP_W = 6;
   localparam int unsigned PASP_AW = 3;
   // word offsets (byte address bits 4:2)
   localparam logic [2:0] PASP_OFS_LEVELS = 3'h0;
   localparam logic [2:0] PASP_OFS_LATCH = 3'h1;
   localparam logic [2:0] PASP_OFS_DIR = 3'h2;
   localparam logic [2:0] PASP_OFS_ANSEL = 3'h3;
   localparam logic [2:0] PASP_OFS_STEER = 3'h4;
   // reset values and fixed bits
   localparam logic [5:0] PASP_DIR_RST = 6'h3f;
   localparam logic [5:0] PASP_ANSEL_RST = 6'h37;
   localparam logic [5:0] PASP_LATCH_RST = 6'h00;
   localparam logic [7:0] PASP_STEER_RST = 8'h00;
   localparam logic [5:0] PASP_IMPL_MASK = 6'h37;
   localparam logic [5:0] PASP_BIT3 = 6'h08;
   localparam logic [7:0] PASP_STEER_MASK_14 = 8'hf7;
   localparam logic [7:0] PASP_STEER_MASK_20 = 8'h33;
   // steering bit positions
   localparam int unsigned PASP_SB_RX = 7;
   localparam int unsigned PASP_SB_SDO = 6;
   localparam int unsigned PASP_SB_SS = 5;
   localparam int unsigned PASP_SB_SDI = 4;
   localparam int unsigned PASP_SB_TX = 2;
   localparam int unsigned PASP_SB_GB = 1;
   localparam int unsigned PASP_SB_GA = 0;
   // peripheral outputs wanting a pin
   typedef struct packed {
      logic sdo_oe;
      logic sdo;
      logic tx_oe;
      logic tx;
      logic g1a;
      logic g2a;
      logic g1b;
      logic g2b;
      logic guard_en;
   } pasp_periph_t;
   // steered peripheral inputs
   typedef struct packed {
      logic rx;
      logic ss_n;
      logic sdi;
   } pasp_pin_in_t;
   // overrides for port c pins 1..6
   typedef struct packed {
      logic [6:1] c_ovr;
      logic [6:1] c_out;
      logic [6:1] c_oe;
   } pasp_pinc_t;
endpackage
`default_nettype wire

/* File: verif/pasp_pins.sv */
// pin model: port a pins seen from outside the device
`default_nettype none
module pasp_pins (
   // device drivers
   input wire logic [5:0] pa_out_i,
   input wire logic [5:0] pa_oe_i,
   // outside drivers
   input wire logic [5:0] ext_i,
   output logic [5:0] pa_in_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // a driven pin shows the device value, otherwise the outside level
   assign pa_in_o = (pa_oe_i & pa_out_i) | (~pa_oe_i & ext_i);
endmodule
`default_nettype wire

/* File: verif/pasp_port_test.sv */
// self-checking bench for the port a and pin steering block
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module pasp_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [4:0] adr = 5'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] wdat = 32'h0;
   logic [31:0] dat_o;
   logic [31:0] rd;
   logic ack_o;
   logic [5:0] pa_in, pa_out, pa_oe;
   logic [5:0] ext = 6'h3f;
   logic [6:1] pc_in = 6'h2a;
   logic pb4 = 1'b1;
   pasp_pkg::pasp_periph_t per = '0;
   pasp_pkg::pasp_pin_in_t pin_in;
   pasp_pkg::pasp_pinc_t pinc;
   int bad_count = 0;
   int num_checks = 0;
   // 250 mhz clock
   always #2 clk_i = ~clk_i;
   pasp_port #(.SMALL_PKG(1'b1)) pasp_port_i (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(wdat), .dat_o(dat_o), .ack_o(ack_o), .pa_in_i(pa_in),
      .pa_out_o(pa_out), .pa_oe_o(pa_oe), .pc_in_i(pc_in), .pb4_in_i(pb4),
      .periph_i(per), .periph_o(pin_in), .pinc_o(pinc));
   pasp_pins pasp_pins_i (.pa_out_i(pa_out), .pa_oe_i(pa_oe), .ext_i(ext),
      .pa_in_o(pa_in));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one classic cycle; ack is read before the edge's own updates land
   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1) begin
         bad_count++;
         end_sim();
      end
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // pins pass two sync flops, so allow settling before a level read
   task automatic settle();
      repeat (4) @(posedge clk_i);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(5'h04, 32'h00);
      rdchk(5'h08, 32'h3f);
      rdchk(5'h0c, 32'h37);
      rdchk(5'h10, 32'h00);
      rdchk(5'h00, 32'h08);
      `CHK(pa_oe, 6'h00)
      $display("test reset values done");
      wr(5'h08, 32'h00);
      rdchk(5'h08, 32'h08);
      wr(5'h0c, 32'h00);
      wr(5'h00, 32'hff);
      rdchk(5'h04, 32'h37);
      `CHK(pa_oe, 6'h37)
      wr(5'h04, 32'hd5);
      rdchk(5'h04, 32'h15);
      ext <= 6'h08;
      settle();
      rdchk(5'h00, 32'h1d);
      wr(5'h0c, 32'h01);
      settle();
      rdchk(5'h00, 32'h1c);
      `CHK(pa_oe[0] & pa_out[0], 1'b1)
      $display("test outputs done");
      wr(5'h08, 32'h3f);
      ext <= 6'h18;
      settle();
      `CHK(pa_oe, 6'h00)
      rdchk(5'h00, 32'h18);
      sel <= 4'he;
      wr(5'h04, 32'h00);
      sel <= 4'hf;
      rdchk(5'h04, 32'h15);
      wr(5'h14, 32'hff);
      rdchk(5'h14, 32'h00);
      $display("test inputs done");
      for (int i = 0; i < 2; i++) begin
         wr(5'h10, i ? 32'hff : 32'h00);
         rdchk(5'h10, i ? 32'hf7 : 32'h00);
         per <= 9'h0ab;
         @(posedge clk_i);
         `CHK(pin_in, i ? 3'b101 : 3'b010)
         `CHK(pinc.c_out[5:2], i ? 4'h5 : 4'ha)
         `CHK(pinc.c_oe[5:2], 4'hf)
         per <= 9'h1e0;
         @(posedge clk_i);
         `CHK(pinc.c_ovr[4:2], i ? 3'b010 : 3'b101)
         `CHK(pinc.c_out[4:2], i ? 3'b010 : 3'b101)
         `CHK(pa_oe[4], i[0])
         rdchk(5'h08, 32'h3f);
      end
      $display("test steering done");
      // a second reset mid-run must bring analog select, steering and latch home again
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(5'h0c, 32'h37);
      rdchk(5'h10, 32'h00);
      rdchk(5'h04, 32'h00);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
